// >>> rtl/pmw_ctrl.sv
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
// How it works
// RULE_01: Fast wake-up only applies leaving sub-clock halt or idle-stopped state, never deep halt.
// RULE_02: The fast-wake enable bit in the mode control register turns fast wake-up on.
// RULE_03: Crystal system clock with fast wake: run on sub-clock until crystal is ready.
// RULE_04: RC system clocks wake after their stabilisation count, fast-wake bit ignored.
// RULE_05: With watchdog off both low-speed oscillators stop, so deep halt has no fast wake.
// RULE_06: Halt picks idle or sleep from idle-enable and clock-keep; select bits pick speed.
// RULE_07: Sub-clock as system clock stops the high-speed oscillator and its /16 /64 taps.
// RULE_08: Software enters slow mode by clearing high-speed select with divider 000 or 001.
// RULE_09: Slow mode switches over only once the low-speed ready flag is high.
// RULE_10: Full speed returns on select or divider 010-111, after the high-speed ready flag; code switches early with watchdog, detector and fast wake off.
// RULE_11: Deep halt needs idle-enable low and both watchdog and voltage detector off.
// RULE_12: Deep halt stops system clock and sub-clock, clears and stops the watchdog.
// RULE_13: Any halt freezes the CPU, sets power-down flag and clears timeout flag.
// RULE_14: Idle-enable low with watchdog or detector on gives sub-clock halt.
// RULE_15: In sub-clock halt a sub-clocked enabled watchdog is cleared and keeps counting.
// RULE_16: Idle-enable high, clock-keep low gives idle with system clock stopped.
// RULE_17: In that idle state a sub-clocked watchdog runs, a system-clocked one stops.
// RULE_18: Divider codes 000/001 pick the sub-clock, 010-111 high speed divided 64 down to 2.
// RULE_19: Low-speed ready rises 1024 crystal or two RC cycles after wake; low in deep halt.
// RULE_20: Waking from idle with clock kept resumes within one to two running cycles.
module pmw_ctrl import pmw_pkg::*; (
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hs_tick,
   input wire logic sub_tick,
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic clr_wdt_req,
   input wire logic wdt_timeout,
   output logic cpu_clk_en,
   output logic sys_clk_en,
   output logic hs_osc_on,
   output logic sub_osc_on,
   output logic hs_div16_en,
   output logic hs_div64_en,
   output logic wdt_clear,
   output logic wdt_run,
   output logic halted,
   output logic power_down_flag,
   output logic watchdog_timeout_flag
);

   // ************************************************************
   // Declarations
   // ************************************************************
   pmw_state_type state_reg, state_next;
   pmw_mode_type mode_reg;
   pmw_cfg_type cfg_reg;
   logic idle_sysclk_keep_reg;
   logic tick_seen_reg, tick_seen_next;
   logic high_osc_ready_flag, low_osc_ready_flag;
   logic div_pulse, div16_pulse, div64_pulse;
   logic sub_sel, run_on_sub, halt_stop, hs_on_next, sub_on_next;
   logic halt_take, wake_fast, wake_target_ok, wake_tick;
   logic clk_pick, cpu_en_next, sys_en_next, wdt_run_next;
   logic pdf_next, to_next;
   logic [CNT_W-1:0] hs_limit, sub_limit;
   logic apb_setup, apb_write, known_addr;
   logic [31:0] rd_word;
   logic pready_next;

   // ************************************************************
   // Clock source decisions
   // ************************************************************
   assign sub_sel = sub_selected(mode_reg); // RULE_18 RULE_08
   // The core stays on the old source until the new one reports ready, except on leaving the sub-clock with watchdog, detector and fast wake all off.
   assign run_on_sub = low_osc_ready_flag && (sub_sel || !high_osc_ready_flag); // RULE_09 RULE_10
   assign halt_stop = state_reg == ST_DEEP || state_reg == ST_SUBHALT || state_reg == ST_IDLE_STOP;
   assign hs_on_next = !halt_stop && !(sub_sel && low_osc_ready_flag); // RULE_07
   // Low-speed oscillators only run when something needs them.
   assign sub_on_next = state_reg != ST_DEEP
      && (cfg_reg.wdt_en || cfg_reg.lvd_en || sub_sel || mode_reg.fast); // RULE_05 RULE_12
   assign hs_limit = cfg_reg.hs_is_rc ? HIGH_SPEED_RC_STABLE_TICKS : HXT_STABLE_TICKS; // RULE_04
   assign sub_limit = cfg_reg.sub_is_rc ? LOW_SPEED_RC_STABLE_TICKS : LXT_STABLE_TICKS; // RULE_19
   // Selected rate: full high speed, divided high speed, or sub-clock.
   assign clk_pick = run_on_sub ? sub_tick : (mode_reg.hsel ? hs_tick : div_pulse); // RULE_06 RULE_18

   // ************************************************************
   // Oscillator stabilisation and division
   // ************************************************************
   pmw_osc_timer #(.W(CNT_W)) u_hs_timer (
      .clock(clock),
      .rstn(rstn),
      .osc_on(hs_osc_on),
      .tick(hs_tick),
      .limit(hs_limit),
      .ready(high_osc_ready_flag)
   );

   pmw_osc_timer #(.W(CNT_W)) u_sub_timer (
      .clock(clock),
      .rstn(rstn),
      .osc_on(sub_osc_on),
      .tick(sub_tick),
      .limit(sub_limit),
      .ready(low_osc_ready_flag)
   );

   pmw_hs_divider #(.W(6)) u_div (
      .clock(clock),
      .rstn(rstn),
      .run(hs_osc_on),
      .tick(hs_tick),
      .div_code(mode_reg.div),
      .sel_pulse(div_pulse),
      .div16_pulse(div16_pulse),
      .div64_pulse(div64_pulse)
   );

   // ************************************************************
   // Operating mode sequencer
   // ************************************************************
   assign halt_take = state_reg == ST_RUN && halt_req;
   // Fast wake needs a live sub-clock and a crystal that still has to stabilise.
   assign wake_fast = (state_reg == ST_SUBHALT || state_reg == ST_IDLE_STOP) && mode_reg.fast
      && !cfg_reg.hs_is_rc && !sub_sel && sub_osc_on; // RULE_01 RULE_02 RULE_03 RULE_04
   assign wake_target_ok = sub_sel ? low_osc_ready_flag : high_osc_ready_flag; // RULE_19
   assign wake_tick = sub_sel ? sub_tick : hs_tick;
   assign tick_seen_next = state_reg == ST_WAKE && (tick_seen_reg || (wake_target_ok && wake_tick));

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_RUN: begin
            if (halt_req) begin
               if (mode_reg.idle) begin
                  state_next = idle_sysclk_keep_reg ? ST_IDLE_RUN : ST_IDLE_STOP; // RULE_06 RULE_16
               end else if (cfg_reg.wdt_en || cfg_reg.lvd_en) begin
                  state_next = ST_SUBHALT; // RULE_14
               end else begin
                  state_next = ST_DEEP; // RULE_11
               end
            end
         end
         ST_DEEP, ST_SUBHALT, ST_IDLE_STOP, ST_IDLE_RUN: begin
            if (wake_req) begin
               state_next = wake_fast ? ST_FAST : ST_WAKE;
            end
         end
         ST_WAKE: begin
            // Resume after the target source is stable plus one of its own edges.
            if (tick_seen_reg) begin
               state_next = ST_RUN; // RULE_20 RULE_04
            end
         end
         ST_FAST: begin
            if (high_osc_ready_flag) begin
               state_next = ST_RUN; // RULE_03
            end
         end
         // The one unused code falls back to run rather than locking the core up.
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   // ************************************************************
   // Clock enables, watchdog control and status flags
   // ************************************************************
   assign cpu_en_next = (state_reg == ST_RUN && clk_pick) || (state_reg == ST_FAST && sub_tick); // RULE_13 RULE_03
   assign sys_en_next = cpu_en_next || (state_reg == ST_IDLE_RUN && clk_pick);
   assign wdt_run_next = cfg_reg.wdt_en && state_reg != ST_DEEP
      && (!(state_reg == ST_SUBHALT || state_reg == ST_IDLE_STOP) || cfg_reg.wdt_from_sub); // RULE_12 RULE_15 RULE_17
   // A halt arriving with a clear sets the flag; a timeout beats a clear of its flag.
   assign pdf_next = halt_take || (power_down_flag && !clr_wdt_req); // RULE_13
   assign to_next = wdt_timeout || (watchdog_timeout_flag && !halt_take && !clr_wdt_req); // RULE_13

   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_reg <= ST_RUN;
         tick_seen_reg <= 1'b0;
         cpu_clk_en <= 1'b0;
         sys_clk_en <= 1'b0;
         hs_osc_on <= 1'b1;
         sub_osc_on <= 1'b0;
         hs_div16_en <= 1'b0;
         hs_div64_en <= 1'b0;
         wdt_clear <= 1'b0;
         wdt_run <= 1'b0;
         halted <= 1'b0;
         power_down_flag <= 1'b0;
         watchdog_timeout_flag <= 1'b0;
      end else begin
         state_reg <= state_next;
         tick_seen_reg <= tick_seen_next;
         cpu_clk_en <= cpu_en_next;
         sys_clk_en <= sys_en_next;
         hs_osc_on <= hs_on_next;
         sub_osc_on <= sub_on_next;
         hs_div16_en <= div16_pulse && hs_osc_on; // RULE_07
         hs_div64_en <= div64_pulse && hs_osc_on; // RULE_07
         wdt_clear <= halt_take; // RULE_12 RULE_15 RULE_17
         wdt_run <= wdt_run_next;
         halted <= state_next != ST_RUN && state_next != ST_FAST; // RULE_13
         power_down_flag <= pdf_next;
         watchdog_timeout_flag <= to_next;
      end
   end

   // ************************************************************
   // APB slave
   // ************************************************************
   // One wait state keeps pready and prdata straight from flip-flops.
   assign apb_setup = psel && penable && !pready;
   assign apb_write = psel && penable && pready && pwrite;
   assign known_addr = paddr == MODE_CTRL_OFS || paddr == SYS_CTRL_OFS
      || paddr == OSC_CFG_OFS || paddr == STATUS_OFS;
   assign pready_next = apb_setup;

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (paddr)
         MODE_CTRL_OFS: begin
            rd_word[7:0] = {mode_reg.div, mode_reg.fast, low_osc_ready_flag, high_osc_ready_flag,
                            mode_reg.idle, mode_reg.hsel};
         end
         SYS_CTRL_OFS: begin
            rd_word[KEEP_BIT] = idle_sysclk_keep_reg;
         end
         OSC_CFG_OFS: begin
            rd_word[4:0] = cfg_reg;
         end
         STATUS_OFS: begin
            rd_word[PDF_BIT] = power_down_flag;
            rd_word[TO_BIT] = watchdog_timeout_flag;
            rd_word[STATE_LSB +: 3] = state_reg;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= pready_next;
         pslverr <= apb_setup && !known_addr;
         prdata <= (apb_setup && !pwrite) ? rd_word : 32'h0000_0000;
      end
   end

   // Software-writable bits; the ready flags in the mode word are read only.
   always_ff @(posedge clock) begin
      if (!rstn) begin
         mode_reg <= pmw_mode_type'({MODE_CTRL_RESET[7:4], MODE_CTRL_RESET[1:0]});
         idle_sysclk_keep_reg <= SYS_CTRL_RESET[KEEP_BIT];
         cfg_reg <= pmw_cfg_type'(OSC_CFG_RESET[4:0]);
      end else if (apb_write && paddr == MODE_CTRL_OFS) begin
         mode_reg <= pmw_mode_type'({pwdata[7:DIV_LSB], pwdata[FAST_BIT], pwdata[IDLE_BIT], pwdata[HSEL_BIT]}); // RULE_02
      end else if (apb_write && paddr == SYS_CTRL_OFS) begin
         idle_sysclk_keep_reg <= pwdata[KEEP_BIT];
      end else if (apb_write && paddr == OSC_CFG_OFS) begin
         cfg_reg <= pmw_cfg_type'(pwdata[LVD_EN_BIT:HS_RC_BIT]);
      end
   end

endmodule // pmw_ctrl

// >>> rtl/pmw_pkg.sv
package pmw_pkg;

   // ************************************************************
   // Register map and field layout
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] MODE_CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] SYS_CTRL_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] OSC_CFG_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] MODE_CTRL_RESET = 8'h03;
   localparam logic [7:0] SYS_CTRL_RESET = 8'h00;
   localparam logic [7:0] OSC_CFG_RESET = 8'h0c;
   localparam int DIV_LSB = 5;
   localparam int FAST_BIT = 4;
   localparam int LRDY_BIT = 3;
   localparam int HRDY_BIT = 2;
   localparam int IDLE_BIT = 1;
   localparam int HSEL_BIT = 0;
   localparam int KEEP_BIT = 7;
   localparam int HS_RC_BIT = 0;
   localparam int SUB_RC_BIT = 1;
   localparam int WDT_EN_BIT = 2;
   localparam int WDT_SUB_BIT = 3;
   localparam int LVD_EN_BIT = 4;
   localparam int PDF_BIT = 0;
   localparam int TO_BIT = 1;
   localparam int STATE_LSB = 4;

   // ************************************************************
   // Oscillator stabilisation counts, in oscillator cycles
   // ************************************************************
   localparam int CNT_W = 11;
   localparam logic [CNT_W-1:0] HXT_STABLE_TICKS = 11'h400;
   localparam logic [CNT_W-1:0] HIGH_SPEED_RC_STABLE_TICKS = 11'h010;
   localparam logic [CNT_W-1:0] LXT_STABLE_TICKS = 11'h400;
   localparam logic [CNT_W-1:0] LOW_SPEED_RC_STABLE_TICKS = 11'h002;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {ST_RUN, ST_DEEP, ST_SUBHALT, ST_IDLE_STOP, ST_IDLE_RUN, ST_WAKE, ST_FAST} pmw_state_type;

   typedef struct packed {
      logic [2:0] div;
      logic fast;
      logic idle;
      logic hsel;
   } pmw_mode_type;

   typedef struct packed {
      logic lvd_en;
      logic wdt_from_sub;
      logic wdt_en;
      logic sub_is_rc;
      logic hs_is_rc;
   } pmw_cfg_type;

   // Divider codes 000 and 001 with the high-speed select low pick the sub-clock.
   function automatic logic sub_selected(input pmw_mode_type m);
      sub_selected = ~m.hsel & (m.div[2:1] == 2'b00);
   endfunction

endpackage

// >>> rtl/pmw_osc_timer.sv
`timescale 1ns/100ps
module pmw_osc_timer import pmw_pkg::*; #(
   parameter int W = CNT_W
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic osc_on,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   output logic ready
);
   if (W < 2) begin : g_chk
      $error("pmw_osc_timer: counter too narrow");
   end

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic ready_next;

   // ************************************************************
   // Stabilisation count
   // ************************************************************
   // A stopped oscillator loses its count, so every restart pays the full time.
   assign cnt_next = !osc_on ? '0 : (tick && !ready) ? W'(cnt_reg + 1'b1) : cnt_reg;
   assign ready_next = osc_on && (ready || (tick && W'(cnt_reg + 1'b1) >= limit));

   always_ff @(posedge clock) begin
      if (!rstn) begin
         cnt_reg <= '0;
         ready <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         ready <= ready_next;
      end
   end
endmodule // pmw_osc_timer

// >>> rtl/pmw_hs_divider.sv
`timescale 1ns/100ps
module pmw_hs_divider import pmw_pkg::*; #(
   parameter int W = 6
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic run,
   input wire logic tick,
   input wire logic [2:0] div_code,
   output logic sel_pulse,
   output logic div16_pulse,
   output logic div64_pulse
);
   if (W != 6) begin : g_chk
      $error("pmw_hs_divider: six stages are needed for divide by 64");
   end

   logic [W-1:0] cnt_reg;
   logic [W-1:0] mask;
   logic [3:0] shift;

   // ************************************************************
   // Tap selection
   // ************************************************************
   // Code 010 divides by 64 and each step up halves the ratio.
   assign shift = 4'd8 - {1'b0, div_code};
   assign mask = W'((7'h01 << shift) - 7'h01);

   // The whole chain clears and stays at zero while the oscillator is off, so the /16 and /64 taps stop too.
   always_ff @(posedge clock) begin
      if (!rstn || !run) begin
         cnt_reg <= '0;
         sel_pulse <= 1'b0;
         div16_pulse <= 1'b0;
         div64_pulse <= 1'b0;
      end else begin
         cnt_reg <= tick ? W'(cnt_reg + 1'b1) : cnt_reg;
         sel_pulse <= tick && ((cnt_reg & mask) == mask);
         div16_pulse <= tick && (cnt_reg[3:0] == 4'hf);
         div64_pulse <= tick && (cnt_reg == 6'h3f);
      end
   end
endmodule // pmw_hs_divider

// >>> verification/pmw_ctrl_props.sv
`timescale 1ns/100ps
module pmw_ctrl_props import pmw_pkg::*; (
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic halt_req,
   input wire logic clr_wdt_req,
   input wire logic wdt_timeout,
   input wire logic cpu_clk_en,
   input wire logic hs_osc_on,
   input wire logic sub_osc_on,
   input wire logic hs_div16_en,
   input wire logic hs_div64_en,
   input wire logic wdt_clear,
   input wire logic wdt_run,
   input wire logic halted,
   input wire logic power_down_flag,
   input wire logic watchdog_timeout_flag
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // A halt taken from run, with no timeout pulse racing it.
   sequence s_halt_taken;
      halt_req && !halted && !wdt_timeout;
   endsequence
   // The fast clock has been off for two edges, so no tap may still be in flight.
   sequence s_hs_off;
      !hs_osc_on ##1 !hs_osc_on;
   endsequence

   chk_halt_entry: assert property (s_halt_taken |=> halted && power_down_flag && !watchdog_timeout_flag)
      else $error("halt entry flags wrong");
   chk_wdt_clear: assert property ($rose(halted) |-> wdt_clear ##1 !wdt_clear)
      else $error("watchdog clear pulse wrong");
   chk_cpu_held: assert property (halted ##1 halted |-> !cpu_clk_en)
      else $error("cpu clock runs while halted");
   chk_taps_stop: assert property (s_hs_off |-> !hs_div16_en && !hs_div64_en)
      else $error("divided taps run with fast oscillator off");
   chk_deep_quiet: assert property (halted && !sub_osc_on |-> !wdt_run)
      else $error("watchdog runs in deep halt");
   chk_timeout_set: assert property (wdt_timeout |=> watchdog_timeout_flag)
      else $error("timeout flag not set");
   chk_clr_flags: assert property (clr_wdt_req && !wdt_timeout && !halt_req |=> !power_down_flag)
      else $error("power down flag not cleared");
   chk_ready_pulse: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("ready pulse wrong");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule // pmw_ctrl_props

bind pmw_ctrl pmw_ctrl_props u_props (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .halt_req(halt_req), .clr_wdt_req(clr_wdt_req),
   .wdt_timeout(wdt_timeout), .cpu_clk_en(cpu_clk_en), .hs_osc_on(hs_osc_on), .sub_osc_on(sub_osc_on),
   .hs_div16_en(hs_div16_en), .hs_div64_en(hs_div64_en), .wdt_clear(wdt_clear), .wdt_run(wdt_run),
   .halted(halted), .power_down_flag(power_down_flag), .watchdog_timeout_flag(watchdog_timeout_flag));

// >>> verification/testbench.sv
`timescale 1ns/100ps
module testbench import pmw_pkg::*;;
   typedef struct packed {
      logic [7:0] cfg, sys, mode;
      logic [2:0] st;
      logic wdt, sub;
      logic [10:0] wmin, wmax;
   } pmw_row_type;
   // Halt cases: config, keep bit, mode, state, watchdog run, sub osc, wake window.
   pmw_row_type rows [0:7] = '{'{8'h0c, 8'h00, 8'h03, 3'h3, 1'b1, 1'b1, 11'd1024, 11'd1040},
      '{8'h04, 8'h00, 8'h03, 3'h3, 1'b0, 1'b1, 11'd1024, 11'd1040},
      '{8'h0c, 8'h80, 8'h03, 3'h4, 1'b1, 1'b1, 11'd1, 11'd4},
      '{8'h0c, 8'h00, 8'h01, 3'h2, 1'b1, 1'b1, 11'd1024, 11'd1040},
      '{8'h10, 8'h00, 8'h01, 3'h2, 1'b0, 1'b1, 11'd1024, 11'd1040},
      '{8'h0d, 8'h00, 8'h01, 3'h2, 1'b1, 1'b1, 11'd17, 11'd21},
      '{8'h00, 8'h00, 8'h01, 3'h1, 1'b0, 1'b0, 11'd1024, 11'd1040},
      '{8'h00, 8'h00, 8'h11, 3'h1, 1'b0, 1'b0, 11'd1024, 11'd1040}};
   logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, hs_tick = 0, sub_tick = 0, err;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] evt = '0;
   logic [1:0] tcnt = '0;
   logic pready, pslverr, cpu_clk_en, sys_clk_en, hs_osc_on, sub_osc_on, hs_div16_en, hs_div64_en;
   logic wdt_clear, wdt_run, halted, power_down_flag, watchdog_timeout_flag;
   int miscompares = 0, check_count = 0, n, g, i, k;

   pmw_ctrl DUT (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hs_tick(hs_tick), .sub_tick(sub_tick), .halt_req(evt[0]), .wake_req(evt[1]),
      .clr_wdt_req(evt[2]), .wdt_timeout(evt[3]), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
      .hs_osc_on(hs_osc_on), .sub_osc_on(sub_osc_on), .hs_div16_en(hs_div16_en),
      .hs_div64_en(hs_div64_en), .wdt_clear(wdt_clear), .wdt_run(wdt_run), .halted(halted),
      .power_down_flag(power_down_flag), .watchdog_timeout_flag(watchdog_timeout_flag));

   always #20 clock = ~clock;
   // Oscillators tick only while enabled; the sub clock is a quarter of the fast one.
   always @(posedge clock) begin
      tcnt <= tcnt + 2'd1;
      hs_tick <= hs_osc_on;
      sub_tick <= sub_osc_on & (tcnt == 2'd3);
   end

   // ****************************************
   // Tasks
   // ****************************************
   task check(input string w, input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, s);
      end
   endtask
   // The request is held until ready is sampled high, then released.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do @(posedge clock); while (pready !== 1'b1 && n++ < 20);
      rd = prdata;
      err = pslverr;
      check("apb ready", 32'(pready), 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task pulse(input int b);
      @(posedge clock);
      evt[b] <= 1'b1;
      @(posedge clock);
      evt[b] <= 1'b0;
   endtask
   // Polls a ready flag; bounded because a dead oscillator would hang here.
   task poll(input int b);
      k = 0;
      rd = '0;
      while (rd[b] !== 1'b1 && k++ < 1500) apb(1'b0, MODE_CTRL_OFS, 32'h0);
      check("ready flag", 32'(rd[b]), 32'h1);
   endtask
   task gap(output int c);
      n = 0;
      do @(posedge clock); while (cpu_clk_en !== 1'b1 && n++ < 300);
      c = 0;
      do begin
         @(posedge clock);
         c++;
      end while (cpu_clk_en !== 1'b1 && c < 300);
   endtask
   task test_done;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      apb(1'b0, MODE_CTRL_OFS, 32'h0);
      check("mode reset", rd & 32'hf3, 32'h03);
      apb(1'b0, OSC_CFG_OFS, 32'h0);
      check("cfg reset", rd, 32'h0c);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped error", 32'(err), 32'h1);
      pulse(3);
      apb(1'b0, STATUS_OFS, 32'h0);
      check("timeout flag", 32'(rd[1]), 32'h1);
      pulse(2);
      apb(1'b0, STATUS_OFS, 32'h0);
      check("flags cleared", 32'(rd[1:0]), 32'h0);
      $display("reset and flags done");
      // Every divider code, then the undivided fast clock.
      apb(1'b1, OSC_CFG_OFS, 32'h0e);
      for (i = 0; i < 9; i++) begin
         apb(1'b1, MODE_CTRL_OFS, (i == 8) ? 32'h01 : 32'(i << 5));
         poll((i < 2) ? LRDY_BIT : HRDY_BIT);
         repeat (140) @(posedge clock);
         gap(g);
         check("cpu rate", 32'(g), (i < 2) ? 32'd4 : (i == 8) ? 32'd1 : 32'(1 << (8 - i)));
         if (i < 2) check("fast osc off", 32'(hs_osc_on), 32'h0);
         if (i < 2) check("taps off", 32'({hs_div16_en, hs_div64_en}), 32'h0);
      end
      // Both taps must run while the fast oscillator runs undivided.
      g = 0;
      k = 0;
      repeat (128) begin
         @(posedge clock);
         g += int'(hs_div64_en);
         k += int'(hs_div16_en);
      end
      check("div64 taps", 32'(g), 32'd2);
      check("div16 taps", 32'(k), 32'd8);
      $display("divider sweep done");
      for (i = 0; i < 8; i++) begin
         apb(1'b1, OSC_CFG_OFS, 32'(rows[i].cfg));
         apb(1'b1, SYS_CTRL_OFS, 32'(rows[i].sys));
         apb(1'b1, MODE_CTRL_OFS, 32'(rows[i].mode));
         pulse(3);
         pulse(0);
         repeat (3) @(posedge clock);
         check("watchdog run", 32'(wdt_run), 32'(rows[i].wdt));
         check("sub osc", 32'(sub_osc_on), 32'(rows[i].sub));
         check("sys clock", 32'(sys_clk_en), 32'(rows[i].st == 3'h4));
         apb(1'b0, STATUS_OFS, 32'h0);
         check("halt state", 32'({rd[6:4], rd[1:0]}), 32'({rows[i].st, 2'b01}));
         apb(1'b0, MODE_CTRL_OFS, 32'h0);
         if (!rows[i].sub) check("low ready in deep", 32'(rd[3]), 32'h0);
         pulse(1);
         g = 0;
         do begin
            @(posedge clock);
            g++;
         end while (halted && g < 2000);
         check("wake time", 32'(g >= rows[i].wmin && g <= rows[i].wmax), 32'h1);
         poll(HRDY_BIT);
         $display("halt case %0d done", i);
      end
      // Fast wake from sub-clock halt: run on the sub clock, then hand over.
      apb(1'b1, OSC_CFG_OFS, 32'h0e);
      apb(1'b1, MODE_CTRL_OFS, 32'h11);
      poll(LRDY_BIT);
      pulse(0);
      repeat (3) @(posedge clock);
      pulse(1);
      repeat (2) @(posedge clock);
      check("fast wake", 32'(halted), 32'h0);
      apb(1'b0, MODE_CTRL_OFS, 32'h0);
      check("fast ready early", 32'(rd[HRDY_BIT]), 32'h0);
      gap(g);
      check("sub rate", 32'(g), 32'd4);
      poll(HRDY_BIT);
      repeat (20) @(posedge clock);
      gap(g);
      check("crystal rate", 32'(g), 32'd1);
      $display("fast wake done");
      test_done;
   end

   // Cuts a hang short; the run needs well under half this span.
   initial begin
      repeat (60000) @(posedge clock);
      miscompares++;
      test_done;
   end
endmodule // testbench
